// *** rtl/dac_cmd_defines.vh ***
// Purpose: Constants for the octal converter command decoder
// Assumes: 24-bit frames (command byte, MS data byte, LS data byte)
// Notes:   Definitions only
`ifndef DAC_CMD_DEFINES_VH
`define DAC_CMD_DEFINES_VH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define CMD_MSB         23
`define CMD_LSB         20
`define ADDR_MSB        19
`define ADDR_LSB        16
`define ADDR_TOP        19
`define CODE_MSB        15
`define CODE_LSB        4
`define PMODE_MSB       14
`define PMODE_LSB       13
`define PSEL_MSB        12
`define PSEL_LSB        5

// ----------------------------------------
// Commands and codes
// ----------------------------------------
`define CMD_WRITE_UPD_ALL 4'h2
`define CMD_POWER         4'h4
`define ADDR_BROADCAST    4'hf
`define PMODE_ON          2'h0
`define PMODE_1K          2'h1
`define PMODE_100K        2'h2
`define PMODE_HIZ         2'h3
`define CODE_RESET        12'h000
`define NUM_CH            8
`define CODE_W            12
`define IDX_START         4'h0
`define IDX_STEP          4'h1
`define CH_ADDR_RESET     3'h0

`endif

// *** rtl/dac_code_bank.v ***
// Purpose: Eight 12-bit code registers with a registered read port
// Assumes: One write per cycle; bulk write loads all entries
// Notes:   Read data comes from a flip-flop
`timescale 1ns/1ps
`include "dac_cmd_defines.vh"

module dac_code_bank (
  // Clock and reset
  input  wire                     sys_clk,
  input  wire                     reset_n,
  // Write side
  input  wire                     wr_en,
  input  wire                     wr_all,
  input  wire [2:0]               wr_addr,
  input  wire [`CODE_W-1:0]       wr_data,
  // Read side
  input  wire [2:0]               rd_addr,
  output reg  [`CODE_W-1:0]       rd_data
);

  reg [`CODE_W-1:0] mem [0:`NUM_CH-1];

  genvar g;
  generate
    for (g = 0; g < `NUM_CH; g = g + 1) begin : entry
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
          mem[g] <= `CODE_RESET;
        else if (wr_en && (wr_all || wr_addr == g))
          mem[g] <= wr_data;
      end
    end
  endgenerate

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      rd_data <= `CODE_RESET;
    else
      rd_data <= mem[rd_addr];
  end

endmodule // dac_code_bank

// *** rtl/dac_cmd_decoder.v ***
// Purpose: Decode global-update writes and power-down commands for eight channels
// Assumes: Frames arrive already deserialised and in the sys_clk domain
// Notes:   Other commands are ignored; analog side sees codes and modes only
//
// Contract
// R1 - Channel address A..H loads that input register, then all outputs update
// R2 - Code is MS byte plus upper LS nibble; lower nibble ignored
// R3 - Address with top bit set, not all ones: invalid, nothing changes
// R4 - All-ones address loads every input register, then all outputs update
// R5 - Power command: two-bit mode then select bits H..A; selected only
// R6 - Mode 00 powers up selected channels, output drives stored code
// R7 - Mode 01 powers down selected channels with 1k pull-down
// R8 - Mode 10 powers down selected channels with 100k pull-down
// R9 - Mode 11 powers down selected channels, output high impedance
// R10 - Unselected channels keep power state; no stored code changes
`timescale 1ns/1ps
`include "dac_cmd_defines.vh"

module dac_cmd_decoder (
  // Clock and reset
  input  wire                       sys_clk,
  input  wire                       reset_n,
  // Frame from serial front end
  input  wire                       frame_valid,
  input  wire [23:0]                frame_data,
  // Channel output codes, channel A in the low bits
  output reg  [`NUM_CH*`CODE_W-1:0] out_code,
  // Per channel power and termination
  output reg  [`NUM_CH-1:0]         chan_powered,
  output reg  [`NUM_CH*2-1:0]       chan_term_mode,
  // Busy while the output update walks
  output reg                        busy
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE  = 3'h1;
  localparam ST_COPY  = 3'h2;
  localparam ST_WAIT  = 3'h4;

  // Walk timing, counted from the edge that takes a write frame:
  //   edge 0       frame taken, write latched, busy rises
  //   edge 1       input register written
  //   edge 2       first input register read
  //   edges 3..10  output codes A..H updated, one per edge
  //   edge 10      busy falls; the next frame is taken from edge 11
  // Frames that arrive while busy are dropped, not queued

  reg  [2:0]          state;
  reg  [2:0]          next_state;
  reg  [3:0]          idx;
  reg                 wr_en;
  reg                 wr_all;
  wire [2:0]          rd_addr;
  wire [`CODE_W-1:0]  rd_data;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  // Data bits 3..0 are never read
  wire [3:0] cmd   = frame_data[`CMD_MSB:`CMD_LSB];
  wire [3:0] addr  = frame_data[`ADDR_MSB:`ADDR_LSB];
  wire [1:0] pmode = frame_data[`PMODE_MSB:`PMODE_LSB];
  wire [7:0] psel  = frame_data[`PSEL_MSB:`PSEL_LSB];

  wire power_mode_high_bit = pmode[1];
  wire power_mode_low_bit  = pmode[0];

  // Address classification shared by both the write path and the trigger
  function addr_ok;
    input [3:0] a;
    begin
      addr_ok = (a[3] == 1'b0) || (a == `ADDR_BROADCAST);
    end
  endfunction

  // Same free test for both commands, so no frame is taken mid-walk
  function cmd_hit;
    input [3:0] c;
    input [3:0] want;
    input       free;
    begin
      cmd_hit = free && (c == want);
    end
  endfunction

  wire idle       = (state == ST_IDLE);
  wire take_write = frame_valid && cmd_hit(cmd, `CMD_WRITE_UPD_ALL, idle) &&
                    addr_ok(addr);                                  // [R3]
  wire take_power = frame_valid && cmd_hit(cmd, `CMD_POWER, idle);  // [R5]

  // ----------------------------------------
  // Input register bank
  // ----------------------------------------
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_en  <= 1'b0;
      wr_all <= 1'b0;
    end else begin
      wr_en  <= take_write;                                     // [R1]
      wr_all <= take_write && (addr == `ADDR_BROADCAST);       // [R4]
    end
  end

  // Registered so the bank sees a clean one-cycle request
  reg [2:0]          wr_addr_q;
  reg [`CODE_W-1:0]  wr_data_q;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_addr_q <= `CH_ADDR_RESET;
      wr_data_q <= `CODE_RESET;
    end else if (take_write) begin
      wr_addr_q <= addr[2:0];
      wr_data_q <= frame_data[`CODE_MSB:`CODE_LSB];             // [R2]
    end
  end

  assign rd_addr = idx[2:0];

  dac_code_bank u_bank (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .wr_en   (wr_en),
    .wr_all  (wr_all),
    .wr_addr (wr_addr_q),
    .wr_data (wr_data_q),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // ----------------------------------------
  // Output update walk
  // ----------------------------------------
  // Index runs one past channel H so the last read can land
  wire walk_done = (idx == `NUM_CH);

  // Write lands first, then every input register is copied out in turn
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take_write)
          next_state = ST_WAIT;
      end
      ST_WAIT: begin
        next_state = ST_COPY;
      end
      ST_COPY: begin
        if (walk_done)
          next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      idx   <= `IDX_START;
      busy  <= 1'b0;
    end else begin
      state <= next_state;
      busy  <= (next_state != ST_IDLE);
      if (state == ST_WAIT || state == ST_IDLE)
        idx <= `IDX_START;
      else
        idx <= idx + `IDX_STEP;
    end
  end

  // ----------------------------------------
  // Read pipeline
  // ----------------------------------------
  // Read data lags the index by one cycle
  reg [3:0] copy_ch;
  reg       copy_en;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      copy_ch <= `IDX_START;
      copy_en <= 1'b0;
    end else begin
      copy_ch <= idx;
      copy_en <= (state == ST_COPY) && (idx < `NUM_CH);
    end
  end

  // ----------------------------------------
  // Output code registers
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `NUM_CH; g = g + 1) begin : ch
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
          out_code[g*`CODE_W +: `CODE_W] <= `CODE_RESET;
        else if (copy_en && copy_ch == g)
          out_code[g*`CODE_W +: `CODE_W] <= rd_data;            // [R1] [R4]
      end
    end
  endgenerate

  // ----------------------------------------
  // Power and termination
  // ----------------------------------------
  // Mode 00 clears the termination field as well, so on reads as 00
  generate
    for (g = 0; g < `NUM_CH; g = g + 1) begin : pwr
      // Power commands touch only selected channels, never codes
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          chan_powered[g]        <= 1'b1;
          chan_term_mode[g*2 +: 2] <= `PMODE_ON;
        end else if (take_power && psel[g]) begin               // [R5] [R10]
          chan_powered[g]        <= (pmode == `PMODE_ON);       // [R6]
          chan_term_mode[g*2 +: 2] <= {power_mode_high_bit,
                                       power_mode_low_bit};     // [R7] [R8] [R9]
        end
      end
    end
  endgenerate

endmodule // dac_cmd_decoder

// *** sim/frame_host.sv ***
// Purpose: Host model handing whole frames to the decoder
// Assumes: One frame per call
// Notes:   Data inverted after the strobe so a stale frame never repeats
`timescale 1ns/1ps
module frame_host (
  // Clock
  input  wire logic        sys_clk,
  // Frame
  output logic             frame_valid,
  output logic [23:0]      frame_data
);
  initial begin
    frame_valid = 1'b0;
    frame_data  = 24'h000000;
  end
  task automatic send(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    frame_data  = {c, a, d};
    frame_valid = 1'b1;
    @(negedge sys_clk);
    frame_valid = 1'b0;
    frame_data  = ~frame_data;
  endtask
endmodule // frame_host

// *** sim/dac_cmd_decoder_monitor.sv ***
// Purpose: Port checks for the command decoder
// Assumes: Top module ports only
// Notes:   Bound at the foot
`timescale 1ns/1ps
module dac_cmd_monitor (
  // Ports watched
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        frame_valid,
  input wire logic [23:0] frame_data,
  input wire logic [95:0] out_code,
  input wire logic [7:0]  chan_powered,
  input wire logic [15:0] chan_term_mode,
  input wire logic        busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire wr  = frame_valid && !busy && frame_data[23:20] == 4'h2;
  wire pd  = frame_valid && !busy && frame_data[23:20] == 4'h4;
  wire bad = frame_data[19] && frame_data[19:16] != 4'hf;
  property p_go; wr && !bad |=> busy; endproperty
  a_go: assert property (p_go) else $error("no start");
  property p_len; $rose(busy) |-> busy[*8] ##[1:4] !busy; endproperty
  a_len: assert property (p_len) else $error("busy span");
  property p_bad; wr && bad |=> !busy[*4]; endproperty
  a_bad: assert property (p_bad) else $error("bad addr ran");
  property p_quiet; !busy && !$past(busy) |=> $stable(out_code); endproperty
  a_quiet: assert property (p_quiet) else $error("code moved");
  property p_all;
    wr && frame_data[19:16] == 4'hf |-> ##13 out_code[95:84] == $past(frame_data[15:4], 13)
      && out_code[11:0] == out_code[95:84];
  endproperty
  a_all: assert property (p_all) else $error("broadcast");
  property p_hold; !pd |=> $stable(chan_powered) && $stable(chan_term_mode); endproperty
  a_hold: assert property (p_hold) else $error("power moved");
  property p_pa;
    pd |=> chan_powered[0] == ($past(frame_data[5]) ? $past(frame_data[14:13]) == 2'h0 : $past(chan_powered[0]));
  endproperty
  a_pa: assert property (p_pa) else $error("power A");
  property p_th; pd && frame_data[12] |=> chan_term_mode[15:14] == $past(frame_data[14:13]); endproperty
  a_th: assert property (p_th) else $error("term H");
endmodule // dac_cmd_monitor
bind dac_cmd_decoder dac_cmd_monitor u_dac_cmd_monitor (.sys_clk(sys_clk), .reset_n(reset_n),
  .frame_valid(frame_valid), .frame_data(frame_data), .out_code(out_code),
  .chan_powered(chan_powered), .chan_term_mode(chan_term_mode), .busy(busy));

// *** sim/tb_top.sv ***
// Purpose: Self-checking bench for the command decoder
// Assumes: Frames come from the host model
// Notes:   Every frame sent through op is followed by a full output compare
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        frame_valid;
  logic [23:0] frame_data;
  wire  [95:0] out_code;
  wire  [7:0]  chan_powered;
  wire  [15:0] chan_term_mode;
  wire         busy;
  int          fail_count = 0;
  int          n_compared = 0;
  logic [95:0] ec = 96'h0;
  logic [7:0]  ep = 8'hff;
  logic [15:0] et = 16'h0;
  always #5 sys_clk = ~sys_clk;
  frame_host u_frame_host (.sys_clk(sys_clk), .frame_valid(frame_valid), .frame_data(frame_data));
  dac_cmd_decoder u_dac_cmd_decoder (.sys_clk(sys_clk), .reset_n(reset_n), .frame_valid(frame_valid),
    .frame_data(frame_data), .out_code(out_code), .chan_powered(chan_powered),
    .chan_term_mode(chan_term_mode), .busy(busy));
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Wait out the update, compare all outputs
  task automatic settle;
    int i;
    repeat (2) @(negedge sys_clk);
    for (i = 0; i < 20 && busy !== 1'b0; i++) @(negedge sys_clk);
    if (i == 20) begin
      fail_count++;
      final_report();
    end else begin
      chk(out_code, ec);
      chk(chan_powered, ep);
      chk(chan_term_mode, et);
    end
  endtask
  // Send one frame, then settle
  task automatic op(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
    u_frame_host.send(c, a, d);
    settle();
  endtask
  task automatic t_write;
    for (int k = 0; k < 8; k++) begin
      ec[12*k +: 12] = 12'h5a0 + 12'(k) * 12'h011;
      op(4'h2, 4'(k), {ec[12*k +: 12], 4'h9});
    end
    for (int a = 8; a < 15; a++) op(4'h2, 4'(a), 16'hfff0);
    $display("t_write done");
  endtask
  task automatic t_bcast;
    ec = {8{12'h3c7}};
    op(4'h2, 4'hf, 16'h3c7e);
    $display("t_bcast done");
  endtask
  task automatic t_power;
    logic [9:0] pw [5] = '{10'h181, 10'h23c, 10'h342, 10'h018, 10'h0ff};
    for (int j = 0; j < 5; j++) begin
      for (int k = 0; k < 8; k++) if (pw[j][k]) begin
        ep[k] = pw[j][9:8] == 2'h0;
        et[2*k +: 2] = pw[j][9:8];
      end
      op(4'h4, 4'h7, {1'b1, pw[j], 5'h1f});
    end
    $display("t_power done");
  endtask
  // Frames that arrive during the walk are dropped
  task automatic t_busy;
    ec[12 +: 12] = 12'h6b2;
    u_frame_host.send(4'h2, 4'h1, 16'h6b25);
    chk(busy, 96'h1);
    u_frame_host.send(4'h4, 4'h0, 16'h7fe0);
    u_frame_host.send(4'h2, 4'h2, 16'h1110);
    settle();
    $display("t_busy done");
  endtask
  // Reset in mid-walk returns every output to its power-on state
  task automatic t_reset;
    u_frame_host.send(4'h2, 4'h5, 16'h9d40);
    repeat (3) @(negedge sys_clk);
    reset_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    ec = 96'h0;
    ep = 8'hff;
    et = 16'h0;
    chk(out_code, ec);
    chk(chan_powered, ep);
    chk(chan_term_mode, et);
    chk(busy, 96'h0);
    reset_n = 1'b1;
    ec[84 +: 12] = 12'h0e1;
    op(4'h2, 4'h7, 16'h0e1f);
    $display("t_reset done");
  endtask
  initial begin
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    t_write();
    t_power();
    t_busy();
    t_bcast();
    t_reset();
    final_report();
  end
endmodule // tb_top
